// ==== hdl/akps_defs.svh ====
// Purpose: Offsets, field positions, encodings and reset values of the shell
// Assumes: Included by bare name, once per compilation unit
// Notes: Definitions only
`ifndef AKPS_DEFS_SVH
`define AKPS_DEFS_SVH
`define AKPS_LITE_AW 8
`define AKPS_ADDR_W 64
`define AKPS_OFF_CTRL 8'h00
`define AKPS_OFF_SRC_LO 8'h10
`define AKPS_OFF_SRC_HI 8'h14
`define AKPS_OFF_LEN 8'h18
`define AKPS_BIT_START 0
`define AKPS_BIT_DONE 1
`define AKPS_BIT_IDLE 2
`define AKPS_BURST_INCR 2'h1
`define AKPS_RESP_OKAY 2'h0
`define AKPS_MAX_BEATS 16
`define AKPS_REG_RESET 32'h0000_0000
`endif

// ==== hdl/akps_fifo.sv ====
// Purpose: Flip-flop FIFO between memory reads and the stream output
// Assumes: Synchronous active-high reset
// Notes: Depth must be a power of two
`timescale 1ns/1ps
module akps_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  akps_fifo_if.store fifo
);
  import akps_pkg::*;

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } akps_fifo_state_t;

  akps_fifo_state_t s_q;
  akps_fifo_state_t s_d;
  logic wr_en;
  logic rd_en;

  always_comb begin
    s_d = s_q;
    wr_en = fifo.in_valid && (s_q.cnt != (PW + 1)'(DEPTH));
    rd_en = fifo.out_ready && (s_q.cnt != '0);
    if (wr_en) begin
      s_d.mem[s_q.wr] = fifo.in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (rd_en) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (PW + 1)'(wr_en) - (PW + 1)'(rd_en);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fifo.in_ready = (s_q.cnt != (PW + 1)'(DEPTH));
  assign fifo.out_valid = (s_q.cnt != '0);
  assign fifo.out_data = s_q.mem[s_q.rd];
  assign fifo.level = s_q.cnt;
endmodule : akps_fifo

// ==== hdl/akps_fifo_if.sv ====
// Purpose: Carrier between the kernel and its data buffer
// Assumes: One filler, one store
// Notes: Level counts stored words
`timescale 1ns/1ps
interface akps_fifo_if #(
  parameter int W = 32,
  parameter int LW = 5
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic [LW-1:0] level;
  modport fill (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data, level);
  modport store (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data, level);
endinterface : akps_fifo_if

// ==== hdl/akps_kernel.sv ====
// Purpose: Kernel shell: control slave, memory read master, stream output
// Assumes: Platform drives the reset synchronously to CLK_IN
// Notes: Reads LEN words from SRC and streams them out, then flags done
`timescale 1ns/1ps
`include "akps_defs.svh"
module akps_kernel #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 16,
  parameter int MAX_BEATS = `AKPS_MAX_BEATS,
  parameter akps_pkg::akps_mode_t MODE = akps_pkg::AKPS_MODE_HANDSHAKE
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // No second clock, reset or crossing
  input wire logic S_AXI_CONTROL_AWVALID_IN,
  output logic S_AXI_CONTROL_AWREADY_OUT,
  input wire logic [`AKPS_LITE_AW-1:0] S_AXI_CONTROL_AWADDR_IN,
  input wire logic S_AXI_CONTROL_WVALID_IN,
  output logic S_AXI_CONTROL_WREADY_OUT,
  input wire logic [31:0] S_AXI_CONTROL_WDATA_IN,
  input wire logic [3:0] S_AXI_CONTROL_WSTRB_IN,
  output logic S_AXI_CONTROL_BVALID_OUT,
  input wire logic S_AXI_CONTROL_BREADY_IN,
  output logic [1:0] S_AXI_CONTROL_BRESP_OUT,
  input wire logic S_AXI_CONTROL_ARVALID_IN,
  output logic S_AXI_CONTROL_ARREADY_OUT,
  input wire logic [`AKPS_LITE_AW-1:0] S_AXI_CONTROL_ARADDR_IN,
  output logic S_AXI_CONTROL_RVALID_OUT,
  input wire logic S_AXI_CONTROL_RREADY_IN,
  output logic [31:0] S_AXI_CONTROL_RDATA_OUT,
  output logic [1:0] S_AXI_CONTROL_RRESP_OUT,
  output logic M_AXI_GMEM_ARVALID_OUT,
  input wire logic M_AXI_GMEM_ARREADY_IN,
  output logic [`AKPS_ADDR_W-1:0] M_AXI_GMEM_ARADDR_OUT,
  output logic [7:0] M_AXI_GMEM_ARLEN_OUT,
  output logic [2:0] M_AXI_GMEM_ARSIZE_OUT,
  output logic [1:0] M_AXI_GMEM_ARBURST_OUT,
  input wire logic M_AXI_GMEM_RVALID_IN,
  output logic M_AXI_GMEM_RREADY_OUT,
  input wire logic [DATA_W-1:0] M_AXI_GMEM_RDATA_IN,
  input wire logic M_AXI_GMEM_RLAST_IN,
  output logic M_AXIS_TVALID_OUT,
  input wire logic M_AXIS_TREADY_IN,
  output logic [DATA_W-1:0] M_AXIS_TDATA_OUT,
  output logic M_AXIS_TLAST_OUT
  // Interrupt port left out, never tied off
);
  import akps_pkg::*;

  localparam int BYTES = DATA_W / 8;
  localparam logic [2:0] SIZE_CODE = 3'($clog2(BYTES));
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ************************************************
  // Elaboration checks
  // ************************************************
  if (MODE == AKPS_MODE_FREE_RUN) begin : g_mode_chk
    // A memory master is always present here
    $error("Free-running control cannot own a memory master");
  end
  if (DATA_W < 32 || DATA_W > 1024 || (1 << $clog2(DATA_W)) != DATA_W)
  begin : g_width_chk
    $error("Data width must be a power of two from 32 to 1024");
  end
  if (MAX_BEATS < 1 || MAX_BEATS > 256) begin : g_beats_chk
    $error("Burst length must lie between 1 and 256 beats");
  end

  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    logic [1:0] rst_pipe;
    logic wr_rdy;
    logic b_vld;
    logic rd_rdy;
    logic r_vld;
    logic [31:0] r_data;
    logic start;
    logic done;
    logic [63:0] src;
    logic [31:0] len;
    akps_run_t st;
    logic ar_vld;
    logic [`AKPS_ADDR_W-1:0] ar_addr;
    logic [7:0] ar_len;
    logic [31:0] ar_left;
    logic [31:0] out_left;
    logic rrdy;
    logic t_vld;
    logic [DATA_W-1:0] t_data;
    logic t_last;
  } akps_state_t;

  akps_state_t s_q;
  akps_state_t s_d;
  logic rst;
  logic wr_hit;
  logic rd_hit;
  logic push;
  logic pop;
  logic [8:0] beats;
  int lvl_next;

  akps_fifo_if #(.W(DATA_W), .LW(LW)) fif ();

  akps_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) akps_fifo_i (
    .clk_in(CLK_IN),
    .rst_in(rst),
    .fifo(fif.store)
  );

  // ************************************************
  // Register helpers
  // ************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return v;
  endfunction : merge

  function automatic logic [31:0] read_reg(
      input logic [`AKPS_LITE_AW-1:0] a, input akps_state_t s);
    logic [31:0] v;
    v = `AKPS_REG_RESET;
    if (a == `AKPS_OFF_CTRL) begin
      v[`AKPS_BIT_START] = s.start;
      v[`AKPS_BIT_DONE] = s.done;
      v[`AKPS_BIT_IDLE] = (s.st == AKPS_ST_IDLE);
    end else if (a == `AKPS_OFF_SRC_LO) begin
      v = s.src[31:0];
    end else if (a == `AKPS_OFF_SRC_HI) begin
      v = s.src[63:32];
    end else if (a == `AKPS_OFF_LEN) begin
      v = s.len;
    end
    return v;
  endfunction : read_reg

  // ************************************************
  // Next state
  // ************************************************
  assign rst = s_q.rst_pipe[1];
  assign fif.in_valid = M_AXI_GMEM_RVALID_IN && s_q.rrdy;
  assign fif.in_data = M_AXI_GMEM_RDATA_IN;
  assign fif.out_ready = !s_q.t_vld || M_AXIS_TREADY_IN;

  always_comb begin
    s_d = s_q;
    // Two stages keep reset fan-out off the input pin
    s_d.rst_pipe = {s_q.rst_pipe[0], !RST_N_IN};
    push = fif.in_valid && fif.in_ready;
    pop = fif.out_valid && fif.out_ready;
    wr_hit = s_q.wr_rdy && S_AXI_CONTROL_AWVALID_IN &&
             S_AXI_CONTROL_WVALID_IN;
    rd_hit = s_q.rd_rdy && S_AXI_CONTROL_ARVALID_IN;
    beats = (s_q.ar_left > 32'(MAX_BEATS)) ? 9'(MAX_BEATS) :
            s_q.ar_left[8:0];
    lvl_next = int'(fif.level) + int'(push) - int'(pop);

    // Control slave: address and data taken together
    s_d.wr_rdy = S_AXI_CONTROL_AWVALID_IN && S_AXI_CONTROL_WVALID_IN &&
                 !s_q.wr_rdy && !s_q.b_vld;
    s_d.b_vld = wr_hit || (s_q.b_vld && !S_AXI_CONTROL_BREADY_IN);
    s_d.rd_rdy = S_AXI_CONTROL_ARVALID_IN && !s_q.rd_rdy && !s_q.r_vld;
    s_d.r_vld = rd_hit || (s_q.r_vld && !S_AXI_CONTROL_RREADY_IN);
    if (rd_hit) begin
      s_d.r_data = read_reg(S_AXI_CONTROL_ARADDR_IN, s_q);
      if (S_AXI_CONTROL_ARADDR_IN == `AKPS_OFF_CTRL) begin
        s_d.done = 1'b0;
      end
    end
    if (wr_hit) begin
      if (S_AXI_CONTROL_AWADDR_IN == `AKPS_OFF_CTRL) begin
        if (S_AXI_CONTROL_WSTRB_IN[0] &&
            S_AXI_CONTROL_WDATA_IN[`AKPS_BIT_START]) begin
          s_d.start = 1'b1;
        end
      end else if (S_AXI_CONTROL_AWADDR_IN == `AKPS_OFF_SRC_LO) begin
        s_d.src[31:0] = merge(s_q.src[31:0], S_AXI_CONTROL_WDATA_IN,
                              S_AXI_CONTROL_WSTRB_IN);
      end else if (S_AXI_CONTROL_AWADDR_IN == `AKPS_OFF_SRC_HI) begin
        s_d.src[63:32] = merge(s_q.src[63:32], S_AXI_CONTROL_WDATA_IN,
                               S_AXI_CONTROL_WSTRB_IN);
      end else if (S_AXI_CONTROL_AWADDR_IN == `AKPS_OFF_LEN) begin
        s_d.len = merge(s_q.len, S_AXI_CONTROL_WDATA_IN,
                        S_AXI_CONTROL_WSTRB_IN);
      end
    end

    // Run sequence
    unique case (s_q.st)
      AKPS_ST_IDLE: begin
        if (s_q.start) begin
          s_d.start = 1'b0;
          s_d.ar_addr = s_q.src;
          s_d.ar_left = s_q.len;
          s_d.out_left = s_q.len;
          if (s_q.len == 32'h0000_0000) begin
            s_d.done = 1'b1;
          end else begin
            s_d.st = AKPS_ST_ADDR;
          end
        end
      end
      AKPS_ST_ADDR: begin
        if (!s_q.ar_vld) begin
          s_d.ar_vld = 1'b1;
          s_d.ar_len = 8'(beats - 9'h001);
        end else if (M_AXI_GMEM_ARREADY_IN) begin
          s_d.ar_vld = 1'b0;
          // Bursts may cross 4 KiB pages; source must be burst aligned
          s_d.ar_addr = s_q.ar_addr +
                        64'((32'(s_q.ar_len) + 32'd1) * BYTES);
          s_d.ar_left = s_q.ar_left - (32'(s_q.ar_len) + 32'd1);
          s_d.st = AKPS_ST_DATA;
        end
      end
      AKPS_ST_DATA: begin
        if (push && M_AXI_GMEM_RLAST_IN) begin
          s_d.st = (s_q.ar_left == 32'h0000_0000) ? AKPS_ST_DRAIN :
                   AKPS_ST_ADDR;
        end
      end
      AKPS_ST_DRAIN: begin
      end
    endcase

    // Stream output register
    if (pop) begin
      s_d.t_vld = 1'b1;
      s_d.t_data = fif.out_data;
      s_d.t_last = (s_q.out_left == 32'h0000_0001);
      s_d.out_left = s_q.out_left - 32'd1;
    end else if (M_AXIS_TREADY_IN) begin
      s_d.t_vld = 1'b0;
    end
    // Done set wins over a same-cycle clear on read
    if (s_q.t_vld && M_AXIS_TREADY_IN && s_q.t_last) begin
      s_d.done = 1'b1;
      s_d.st = AKPS_ST_IDLE;
    end

    // Ready only while the next beat is sure to fit
    s_d.rrdy = (lvl_next < FIFO_DEPTH);
  end

  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= AKPS_ST_IDLE;
      s_q.rst_pipe <= s_d.rst_pipe;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign S_AXI_CONTROL_AWREADY_OUT = s_q.wr_rdy;
  assign S_AXI_CONTROL_WREADY_OUT = s_q.wr_rdy;
  assign S_AXI_CONTROL_BVALID_OUT = s_q.b_vld;
  assign S_AXI_CONTROL_BRESP_OUT = `AKPS_RESP_OKAY;
  assign S_AXI_CONTROL_ARREADY_OUT = s_q.rd_rdy;
  assign S_AXI_CONTROL_RVALID_OUT = s_q.r_vld;
  assign S_AXI_CONTROL_RDATA_OUT = s_q.r_data;
  assign S_AXI_CONTROL_RRESP_OUT = `AKPS_RESP_OKAY;
  assign M_AXI_GMEM_ARVALID_OUT = s_q.ar_vld;
  assign M_AXI_GMEM_ARADDR_OUT = s_q.ar_addr;
  assign M_AXI_GMEM_ARLEN_OUT = s_q.ar_len;
  assign M_AXI_GMEM_ARSIZE_OUT = SIZE_CODE;
  assign M_AXI_GMEM_ARBURST_OUT = `AKPS_BURST_INCR;
  assign M_AXI_GMEM_RREADY_OUT = s_q.rrdy;
  assign M_AXIS_TVALID_OUT = s_q.t_vld;
  assign M_AXIS_TDATA_OUT = s_q.t_data;
  assign M_AXIS_TLAST_OUT = s_q.t_last;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (rst);

  sequence s_launch;
    s_q.st == AKPS_ST_IDLE && s_q.start && s_q.len != 32'h0000_0000;
  endsequence
  sequence s_lite_req;
    wr_hit || rd_hit;
  endsequence
  sequence s_lite_ans;
    (S_AXI_CONTROL_BVALID_OUT || S_AXI_CONTROL_RVALID_OUT);
  endsequence

  a_first_addr: assert property (
    s_launch |-> ##2 (M_AXI_GMEM_ARVALID_OUT &&
      M_AXI_GMEM_ARADDR_OUT == $past(s_q.src, 2)))
    else $error("First burst address differs from programmed base");
  a_burst_incr: assert property (
    M_AXI_GMEM_ARVALID_OUT |-> M_AXI_GMEM_ARBURST_OUT == 2'h1 &&
      32'(M_AXI_GMEM_ARLEN_OUT) < 32'(MAX_BEATS))
    else $error("Burst not incrementing or too long");
  a_full_size: assert property (
    M_AXI_GMEM_ARVALID_OUT |-> (1 << M_AXI_GMEM_ARSIZE_OUT) == BYTES)
    else $error("Narrow burst issued");
  a_ar_hold: assert property (
    M_AXI_GMEM_ARVALID_OUT && !M_AXI_GMEM_ARREADY_IN |=>
      M_AXI_GMEM_ARVALID_OUT && $stable(M_AXI_GMEM_ARADDR_OUT) &&
      $stable(M_AXI_GMEM_ARLEN_OUT))
    else $error("Read request changed before acceptance");
  a_lite_answer: assert property (
    s_lite_req |=> s_lite_ans)
    else $error("Control access not answered next cycle");
  a_reset_pipe: assert property (
    @(posedge CLK_IN) disable iff (1'b0)
    (!RST_N_IN ##1 !RST_N_IN) |-> ##2
      (s_q.st == AKPS_ST_IDLE && !M_AXI_GMEM_ARVALID_OUT && !s_q.done))
    else $error("Reset not applied two cycles after pin");
  a_no_overflow: assert property (
    fif.in_valid |-> fif.in_ready)
    else $error("Read beat accepted with buffer full");
  a_stream_hold: assert property (
    M_AXIS_TVALID_OUT && !M_AXIS_TREADY_IN |=> M_AXIS_TVALID_OUT &&
      $stable(M_AXIS_TDATA_OUT) && $stable(M_AXIS_TLAST_OUT))
    else $error("Stream beat changed while stalled");
  a_done_last: assert property (
    M_AXIS_TVALID_OUT && M_AXIS_TREADY_IN && M_AXIS_TLAST_OUT |=>
      s_q.done && s_q.st == AKPS_ST_IDLE)
    else $error("Done not set after last stream beat");
endmodule : akps_kernel

// ==== hdl/akps_pkg.sv ====
// Purpose: Types shared by the kernel shell modules
// Assumes: Nothing
// Notes: One-hot run states
package akps_pkg;
  typedef enum logic [3:0] {
    AKPS_ST_IDLE = 4'h1,
    AKPS_ST_ADDR = 4'h2,
    AKPS_ST_DATA = 4'h4,
    AKPS_ST_DRAIN = 4'h8
  } akps_run_t;
  typedef enum logic [0:0] {
    AKPS_MODE_HANDSHAKE = 1'h0,
    AKPS_MODE_FREE_RUN = 1'h1
  } akps_mode_t;
endpackage : akps_pkg

// ==== verification/akps_kernel_tb.sv ====
// Purpose: Self-checking bench for the kernel shell
// Assumes: Default parameters, 32-bit data, 16-beat bursts
// Notes: Bench-driven inputs change on the falling edge; memory model outputs change on the rising edge
`timescale 1ns/1ps
module akps_kernel_tb;
  import akps_pkg::*;
  logic clk, rst_n, slow, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, m_arvalid, m_arready, m_rvalid;
  logic m_rready, m_rlast, tvalid, tready, tlast;
  logic [7:0] awaddr, araddr, m_arlen;
  logic [31:0] wdata, rdata, m_rdata, tdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, m_arburst, tmode;
  logic [2:0] m_arsize;
  logic [63:0] m_araddr;
  logic [63:0] arq[$];
  logic [7:0] alq[$];
  logic [31:0] sq[$];
  logic lq[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int beats = 0;

  akps_kernel akps_kernel_i (
    .CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_CONTROL_AWVALID_IN(awvalid), .S_AXI_CONTROL_AWREADY_OUT(awready),
    .S_AXI_CONTROL_AWADDR_IN(awaddr), .S_AXI_CONTROL_WVALID_IN(wvalid),
    .S_AXI_CONTROL_WREADY_OUT(wready), .S_AXI_CONTROL_WDATA_IN(wdata),
    .S_AXI_CONTROL_WSTRB_IN(wstrb), .S_AXI_CONTROL_BVALID_OUT(bvalid),
    .S_AXI_CONTROL_BREADY_IN(bready), .S_AXI_CONTROL_BRESP_OUT(bresp),
    .S_AXI_CONTROL_ARVALID_IN(arvalid), .S_AXI_CONTROL_ARREADY_OUT(arready),
    .S_AXI_CONTROL_ARADDR_IN(araddr), .S_AXI_CONTROL_RVALID_OUT(rvalid),
    .S_AXI_CONTROL_RREADY_IN(rready), .S_AXI_CONTROL_RDATA_OUT(rdata),
    .S_AXI_CONTROL_RRESP_OUT(rresp),
    .M_AXI_GMEM_ARVALID_OUT(m_arvalid), .M_AXI_GMEM_ARREADY_IN(m_arready),
    .M_AXI_GMEM_ARADDR_OUT(m_araddr), .M_AXI_GMEM_ARLEN_OUT(m_arlen),
    .M_AXI_GMEM_ARSIZE_OUT(m_arsize), .M_AXI_GMEM_ARBURST_OUT(m_arburst),
    .M_AXI_GMEM_RVALID_IN(m_rvalid), .M_AXI_GMEM_RREADY_OUT(m_rready),
    .M_AXI_GMEM_RDATA_IN(m_rdata), .M_AXI_GMEM_RLAST_IN(m_rlast),
    .M_AXIS_TVALID_OUT(tvalid), .M_AXIS_TREADY_IN(tready),
    .M_AXIS_TDATA_OUT(tdata), .M_AXIS_TLAST_OUT(tlast)
  );
  akps_mem_model akps_mem_model_i (
    .clk_in(clk), .slow_in(slow), .arvalid_in(m_arvalid),
    .arready_out(m_arready), .araddr_in(m_araddr), .arlen_in(m_arlen),
    .rvalid_out(m_rvalid), .rready_in(m_rready), .rdata_out(m_rdata),
    .rlast_out(m_rlast)
  );

  always #20 clk = ~clk;
  // Mode 0 ready, 1 stalled, 2 every other cycle
  always @(negedge clk) tready <= (tmode == 2'd0) || (tmode == 2'd2 && !tready);
  always @(posedge clk) begin
    if (m_arvalid && m_arready) begin
      arq.push_back(m_araddr);
      alq.push_back(m_arlen);
      check({m_arsize, m_arburst}, {3'h2, 2'h1});
    end
    if (tvalid && tready) begin
      sq.push_back(tdata);
      lq.push_back(tlast);
    end
    if (m_rvalid && m_rready) beats++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic lite_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr = a;
    wdata = d;
    awvalid = 1'b1;
    wvalid = 1'b1;
    while (awready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    check(wready, 1'b1);
    @(negedge clk);
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b1;
    while (bvalid !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    check({bvalid, bresp}, 3'b100);
    @(negedge clk);
    bready = 1'b0;
  endtask : lite_write

  task automatic lite_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr = a;
    arvalid = 1'b1;
    while (arready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    @(negedge clk);
    arvalid = 1'b0;
    rready = 1'b1;
    while (rvalid !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    check({rvalid, rresp}, 3'b100);
    d = rdata;
    @(negedge clk);
    rready = 1'b0;
  endtask : lite_read

  task automatic start_job(input logic [63:0] src, input logic [31:0] len);
    arq.delete(); alq.delete(); sq.delete(); lq.delete();
    beats = 0;
    lite_write(8'h10, src[31:0]);
    lite_write(8'h14, src[63:32]);
    lite_write(8'h18, len);
    lite_write(8'h00, 32'h0000_0001);
  endtask : start_job

  task automatic finish_job(input logic [63:0] src, input int len);
    logic [31:0] d;
    logic [63:0] a;
    int n;
    n = 0;
    d = 32'h0000_0000;
    while (d[1] !== 1'b1 && n < 400) begin lite_read(8'h00, d); n++; end
    check(d[1], 1'b1);
    lite_read(8'h00, d);
    check(d, 32'h0000_0004); // Done cleared by the read, idle again
    check(arq.size(), (len + 15) / 16);
    for (int b = 0; b * 16 < len; b++) begin
      check(arq[b], src + 64'(b * 64));
      check(alq[b], ((len - b * 16 > 16) ? 16 : len - b * 16) - 1);
    end
    check(sq.size(), len);
    for (int k = 0; k < len; k++) begin
      a = src + 64'(4 * k);
      check({lq[k], sq[k]}, {k == len - 1, a[31:0] ^ a[63:32] ^ 32'h5A5A_0000});
    end
  endtask : finish_job

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset_values();
    logic [31:0] d;
    lite_read(8'h00, d);
    check(d, 32'h0000_0004);
    lite_read(8'h10, d);
    check(d, 32'h0000_0000);
    lite_write(8'h10, 32'hDEAD_BEEF);
    wstrb = 4'h5;
    lite_write(8'h10, 32'h1122_3344);
    wstrb = 4'hE;
    lite_write(8'h00, 32'h0000_0001);
    wstrb = 4'hF;
    lite_read(8'h10, d);
    check(d, 32'hDE22_BE44);
    lite_read(8'h00, d);
    check(d, 32'h0000_0004);
    lite_write(8'h40, 32'hDEAD_BEEF);
    lite_read(8'h40, d);
    check(d, 32'h0000_0000);
  endtask : test_reset_values

  task automatic test_two_bursts();
    tmode = 2'd2;
    start_job(64'h0000_0001_2345_6700, 32'd20);
    finish_job(64'h0000_0001_2345_6700, 20);
  endtask : test_two_bursts

  task automatic test_backpressure();
    tmode = 2'd1;
    slow = 1'b1;
    start_job(64'h0000_00A0_0000_1000, 32'd40);
    repeat (120) @(negedge clk);
    check(m_rready, 1'b0);
    check(beats >= 16, 1'b1);
    tmode = 2'd0;
    finish_job(64'h0000_00A0_0000_1000, 40);
    slow = 1'b0;
  endtask : test_backpressure

  task automatic test_zero_len();
    start_job(64'h0000_0000_0000_0400, 32'd0);
    finish_job(64'h0000_0000_0000_0400, 0);
  endtask : test_zero_len

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(40 * 30000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    slow = 1'b0;
    tmode = 2'd0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    test_reset_values();
    test_two_bursts();
    test_backpressure();
    test_zero_len();
    print_verdict();
  end
endmodule : akps_kernel_tb

// ==== verification/akps_mem_model.sv ====
// Purpose: Global memory read slave facing the kernel's read master
// Assumes: One burst outstanding, word-wide beats
// Notes: slow_in makes two idle cycles after every beat instead of one
`timescale 1ns/1ps
module akps_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [63:0] araddr_in,
  input wire logic [7:0] arlen_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic rlast_out
);
  // ****************************************
  // Burst engine
  // ****************************************
  logic busy_q, gap_q;
  logic [63:0] addr_q;
  logic [7:0] left_q;
  initial begin
    busy_q = 1'b0;
    gap_q = 1'b0;
    arready_out = 1'b0;
    rvalid_out = 1'b0;
    rlast_out = 1'b0;
    rdata_out = 32'h0000_0000;
  end
  always @(posedge clk_in) begin
    arready_out <= arvalid_in && !arready_out && !busy_q;
    if (arvalid_in && arready_out) begin
      busy_q <= 1'b1;
      addr_q <= araddr_in;
      left_q <= arlen_in;
    end
    if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      // Released bus must not keep showing the last word
      rdata_out <= ~rdata_out;
      addr_q <= addr_q + 64'h0000_0000_0000_0004;
      left_q <= left_q - 8'h01;
      busy_q <= !rlast_out;
      gap_q <= slow_in;
    end else if (busy_q && !rvalid_out && !gap_q) begin
      rvalid_out <= 1'b1;
      rdata_out <= addr_q[31:0] ^ addr_q[63:32] ^ 32'h5A5A_0000;
      rlast_out <= (left_q == 8'h00);
    end else begin
      gap_q <= 1'b0;
      if (!rvalid_out) begin
        rdata_out <= ~rdata_out;
      end
    end
  end
endmodule : akps_mem_model
